// file: include/dacsc_pkg.sv
// dacsc_pkg: register map, field positions, reset values and types of the
// converter calibration and gain-trim control block.
// assumes nothing beyond a SystemVerilog compiler; holds definitions only
package dacsc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int FIELD_W = 6;
  localparam int COEFF_N = 32;
  localparam int SLOT_W = 5;
  localparam int DIV_W = 12;
  localparam int STEP_W = 9;

  // register offsets
  localparam logic [ADDR_W-1:0] A_I_FINE = 5'h03;
  localparam logic [ADDR_W-1:0] A_I_COARSE = 5'h04;
  localparam logic [ADDR_W-1:0] A_I_CMRES = 5'h05;
  localparam logic [ADDR_W-1:0] A_Q_FINE = 5'h06;
  localparam logic [ADDR_W-1:0] A_Q_COARSE = 5'h07;
  localparam logic [ADDR_W-1:0] A_Q_CMRES = 5'h08;
  localparam logic [ADDR_W-1:0] A_REF_TRIM = 5'h0D;
  localparam logic [ADDR_W-1:0] A_CAL_CTRL = 5'h0E;
  localparam logic [ADDR_W-1:0] A_CAL_STAT = 5'h0F;
  localparam logic [ADDR_W-1:0] A_COEFF_IDX = 5'h10;
  localparam logic [ADDR_W-1:0] A_COEFF_DATA = 5'h11;
  localparam logic [ADDR_W-1:0] A_CAL_CMD = 5'h12;

  // calibration control fields
  localparam int B_DIV_MSB = 2;
  localparam int B_DIV_LSB = 0;
  localparam int B_CLK_EN = 3;
  localparam int B_SEL_I = 4;
  localparam int B_SEL_Q = 5;
  localparam logic [DATA_W-1:0] CTRL_MASK = 8'h3F;
  // command fields
  localparam int B_RD = 2;
  localparam int B_WR = 3;
  localparam int B_START = 4;
  localparam logic [DATA_W-1:0] CMD_MASK = 8'h1C;
  // status fields
  localparam int B_UNCAL_I = 0;
  localparam int B_UNCAL_Q = 1;
  localparam int B_BUSY_I = 2;
  localparam int B_BUSY_Q = 3;
  localparam int B_DONE_I = 6;
  localparam int B_DONE_Q = 7;

  // reset values
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [FIELD_W-1:0] FIELD_RST = 6'h00;
  localparam logic UNCAL_RST = 1'b1;

  // coefficient indexing
  localparam logic [DATA_W-1:0] COEFF_FIRST = 8'h01;
  localparam logic [DATA_W-1:0] COEFF_LAST = 8'h20;

  // calibration timing: divider in converter clock cycles, steps in cal clock cycles
  localparam int CAL_DIV_MIN = 32;
  localparam int CAL_DIV_MAX = 2048;
  localparam logic [2:0] DIV_SEL_TOP = 3'h6;
  localparam int CAL_STEPS = 300;

  // serial frame layout: read flag, two zero bits, address, then data
  localparam int SPI_INSTR_LAST = 7;
  localparam int SPI_FRAME_LAST = 15;
  localparam int SPI_RD_POS = 6;

  typedef struct packed {
    logic [FIELD_W-1:0] ref_trim;
    logic [FIELD_W-1:0] fine_i;
    logic [FIELD_W-1:0] coarse_gain_i;
    logic [FIELD_W-1:0] cm_resistor_i;
    logic [FIELD_W-1:0] fine_q;
    logic [FIELD_W-1:0] coarse_gain_q;
    logic [FIELD_W-1:0] cm_resistor_q;
  } dacsc_trim_t;

  typedef enum logic [2:0] {
    DACSC_CE_IDLE = 3'b001,
    DACSC_CE_RUN = 3'b010,
    DACSC_CE_DONE = 3'b100
  } dacsc_ce_state_t;

  typedef enum logic [2:0] {
    DACSC_SPI_IDLE = 3'b001,
    DACSC_SPI_INSTR = 3'b010,
    DACSC_SPI_DATA = 3'b100
  } dacsc_spi_state_t;

  // cycles of the converter clock per calibration clock cycle
  function automatic logic [DIV_W-1:0] dacsc_div_count(input logic [2:0] sel);
    logic [DIV_W-1:0] n;
    n = DIV_W'(CAL_DIV_MIN) << sel;
    if (sel > DIV_SEL_TOP) begin
      n = DIV_W'(CAL_DIV_MAX);
    end
    return n;
  endfunction : dacsc_div_count

  // {valid, slot} for a coefficient index
  function automatic logic [SLOT_W:0] dacsc_coeff_slot(
    input logic [DATA_W-1:0] idx
  );
    logic ok;
    logic [DATA_W-1:0] off;
    ok = (idx >= COEFF_FIRST) && (idx <= COEFF_LAST);
    off = idx - COEFF_FIRST;
    return {ok, off[SLOT_W-1:0]};
  endfunction : dacsc_coeff_slot

endpackage : dacsc_pkg

// file: rtl/dacsc_cal_engine.sv
// dacsc_cal_engine: calibration sequencer and coefficient store of one
// channel. assumes cal_tick is a one-cycle pulse per calibration clock and
// that start, write and slot come from logic on the same clock.
`timescale 1ns/1ps
module dacsc_cal_engine
  import dacsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cal_tick,
  input wire logic start,
  input wire logic wr_en,
  input wire logic [SLOT_W-1:0] wr_slot,
  input wire logic [FIELD_W-1:0] wr_data,
  input wire logic [SLOT_W-1:0] rd_slot,
  output logic [FIELD_W-1:0] rd_data,
  output logic busy,
  output logic done
);

  logic [FIELD_W-1:0] coeff_mem [COEFF_N];
  dacsc_ce_state_t state_reg;
  logic [STEP_W-1:0] step_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= DACSC_CE_IDLE;
      step_reg <= '0;
    end else if (start) begin
      state_reg <= DACSC_CE_RUN;
      step_reg <= '0;
    end else begin
      case (state_reg)
        DACSC_CE_RUN: begin
          if (cal_tick) begin
            if (step_reg == STEP_W'(CAL_STEPS - 1)) begin
              state_reg <= DACSC_CE_DONE;
            end else begin
              step_reg <= step_reg + STEP_W'(1);
            end
          end
        end
        DACSC_CE_IDLE: state_reg <= DACSC_CE_IDLE;
        DACSC_CE_DONE: state_reg <= DACSC_CE_DONE;
        default: state_reg <= DACSC_CE_IDLE;
      endcase
    end
  end

  assign busy = (state_reg == DACSC_CE_RUN);
  assign done = (state_reg == DACSC_CE_DONE);

  // coefficient store, host writable
  // the analog measurement is outside; coefficients change only by writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int k = 0; k < COEFF_N; k++) begin
        coeff_mem[k] <= FIELD_RST;
      end
    end else if (wr_en) begin
      coeff_mem[wr_slot] <= wr_data;
    end
  end

  assign rd_data = coeff_mem[rd_slot];

  sequence s_start;
    start;
  endsequence

  sequence s_last_step;
    busy && cal_tick && (step_reg == STEP_W'(CAL_STEPS - 1));
  endsequence

  a_start_runs: assert property (@(posedge clk) disable iff (!reset_n)
    s_start |=> busy && !done && (step_reg == '0))
    else $error("start did not begin a fresh run");

  a_run_length: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(done) |-> $past(step_reg) == STEP_W'(CAL_STEPS - 1) &&
      $past(cal_tick))
    else $error("run ended before the full step count");

  a_last_step_done: assert property (@(posedge clk) disable iff (!reset_n)
    s_last_step ##0 !start |=> done)
    else $error("last step did not finish the run");

  a_done_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    done && !start |=> done)
    else $error("done dropped without a new start");

  a_coeff_store: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en |=> coeff_mem[$past(wr_slot)] == $past(wr_data))
    else $error("coefficient write not stored");

endmodule : dacsc_cal_engine

// file: rtl/dacsc_top.sv
// dacsc_top: serial register port, calibration clock divider, trim
// registers and the two channel calibration engines of the converter.
// assumes the host frames each access with spi_cs_n low and runs spi_sclk
// at no more than one eighth of clk; clk is the converter clock.
`timescale 1ns/1ps
module dacsc_top
  import dacsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  output dacsc_trim_t trim_out,
  output logic cal_clock_out,
  output logic cal_run_i,
  output logic cal_run_q
);

  logic cs_s1, cs_s2, sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2;
  logic sck_rise, sck_fall, cs_act;
  dacsc_spi_state_t spi_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] tx_reg;
  logic instr_rd_reg;
  logic [ADDR_W-1:0] instr_addr_reg;
  logic wr_commit_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_mux;
  dacsc_trim_t trim_reg;
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic [DATA_W-1:0] index_reg;
  logic uncal_i_reg, uncal_q_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_n;
  logic cal_tick_reg;
  logic cal_clock_reg;
  logic start_pulse, coeff_wr;
  logic [SLOT_W:0] slot_info;
  logic [FIELD_W-1:0] rd_i, rd_q, coeff_rd;
  logic busy_i, busy_q, done_i, done_q;

  // pins are asynchronous to clk: two flops before any use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      sck_s1 <= spi_sclk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= spi_sdio_in;
      sdi_s2 <= sdi_s1;
    end
  end

  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign cs_act = !cs_s2;
  assign rd_addr = {shift_reg[3:0], sdi_s2};

  // frame sequencer: eight instruction bits, eight data bits, msb first
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spi_state_reg <= DACSC_SPI_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= REG_RST;
      instr_rd_reg <= 1'b0;
      instr_addr_reg <= '0;
    end else if (!cs_act) begin
      spi_state_reg <= DACSC_SPI_IDLE;
      bit_cnt_reg <= '0;
    end else begin
      case (spi_state_reg)
        DACSC_SPI_IDLE: begin
          spi_state_reg <= DACSC_SPI_INSTR;
          bit_cnt_reg <= '0;
        end
        DACSC_SPI_INSTR: begin
          if (sck_rise) begin
            shift_reg <= {shift_reg[DATA_W-2:0], sdi_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(SPI_INSTR_LAST)) begin
              spi_state_reg <= DACSC_SPI_DATA;
              instr_rd_reg <= shift_reg[SPI_RD_POS];
              instr_addr_reg <= rd_addr;
            end
          end
        end
        DACSC_SPI_DATA: begin
          if (sck_rise) begin
            shift_reg <= {shift_reg[DATA_W-2:0], sdi_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(SPI_FRAME_LAST)) begin
              spi_state_reg <= DACSC_SPI_IDLE;
            end
          end
        end
        default: spi_state_reg <= DACSC_SPI_IDLE;
      endcase
    end
  end

  // write strobe one cycle after the last data bit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_commit_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= REG_RST;
    end else begin
      wr_commit_reg <= cs_act && sck_rise && !instr_rd_reg &&
        (spi_state_reg == DACSC_SPI_DATA) &&
        (bit_cnt_reg == 4'(SPI_FRAME_LAST));
      wr_addr_reg <= instr_addr_reg;
      wr_data_reg <= {shift_reg[DATA_W-2:0], sdi_s2};
    end
  end

  // read data is captured once, when the address is complete, and
  // shifted out on falling sclk so the host can sample on rising sclk
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_reg <= REG_RST;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe <= 1'b0;
    end else if (!cs_act) begin
      spi_sdio_oe <= 1'b0;
    end else begin
      if (sck_rise && (spi_state_reg == DACSC_SPI_INSTR) &&
          (bit_cnt_reg == 4'(SPI_INSTR_LAST))) begin
        tx_reg <= rd_mux;
      end else if (sck_fall) begin
        if ((spi_state_reg == DACSC_SPI_DATA) && instr_rd_reg) begin
          spi_sdio_out <= tx_reg[DATA_W-1];
          spi_sdio_oe <= 1'b1;
          tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
        end else begin
          spi_sdio_oe <= 1'b0;
        end
      end
    end
  end

  assign slot_info = dacsc_coeff_slot(index_reg);

  // lowest selected channel answers a read
  always_comb begin
    coeff_rd = FIELD_RST;
    if (slot_info[SLOT_W]) begin
      if (ctrl_reg[B_SEL_I]) begin
        coeff_rd = rd_i;
      end else if (ctrl_reg[B_SEL_Q]) begin
        coeff_rd = rd_q;
      end
    end
  end

  // register readback; unmapped offsets and upper bits read zero
  always_comb begin
    rd_mux = REG_RST;
    case (rd_addr)
      A_I_FINE: rd_mux = DATA_W'(trim_reg.fine_i);
      A_I_COARSE: rd_mux = DATA_W'(trim_reg.coarse_gain_i);
      A_I_CMRES: rd_mux = DATA_W'(trim_reg.cm_resistor_i);
      A_Q_FINE: rd_mux = DATA_W'(trim_reg.fine_q);
      A_Q_COARSE: rd_mux = DATA_W'(trim_reg.coarse_gain_q);
      A_Q_CMRES: rd_mux = DATA_W'(trim_reg.cm_resistor_q);
      A_REF_TRIM: rd_mux = DATA_W'(trim_reg.ref_trim);
      A_CAL_CTRL: rd_mux = ctrl_reg;
      A_CAL_STAT: begin
        rd_mux[B_UNCAL_I] = uncal_i_reg;
        rd_mux[B_UNCAL_Q] = uncal_q_reg;
        rd_mux[B_BUSY_I] = busy_i;
        rd_mux[B_BUSY_Q] = busy_q;
        rd_mux[B_DONE_I] = done_i;
        rd_mux[B_DONE_Q] = done_q;
      end
      A_COEFF_IDX: rd_mux = index_reg;
      // data only while read bit set
      A_COEFF_DATA: begin
        if (cmd_reg[B_RD]) begin
          rd_mux = DATA_W'(coeff_rd);
        end
      end
      A_CAL_CMD: rd_mux = cmd_reg;
      default: rd_mux = REG_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trim_reg <= '0;
    end else if (wr_commit_reg) begin
      case (wr_addr_reg)
        A_I_FINE: trim_reg.fine_i <= wr_data_reg[FIELD_W-1:0];
        A_I_COARSE: trim_reg.coarse_gain_i <= wr_data_reg[FIELD_W-1:0];
        A_I_CMRES: trim_reg.cm_resistor_i <= wr_data_reg[FIELD_W-1:0];
        A_Q_FINE: trim_reg.fine_q <= wr_data_reg[FIELD_W-1:0];
        A_Q_COARSE: trim_reg.coarse_gain_q <= wr_data_reg[FIELD_W-1:0];
        A_Q_CMRES: trim_reg.cm_resistor_q <= wr_data_reg[FIELD_W-1:0];
        A_REF_TRIM: trim_reg.ref_trim <= wr_data_reg[FIELD_W-1:0];
        default: trim_reg <= trim_reg;
      endcase
    end
  end

  assign trim_out = trim_reg;

  // control, index and command registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= REG_RST;
      index_reg <= REG_RST;
      cmd_reg <= REG_RST;
    end else if (wr_commit_reg) begin
      if (wr_addr_reg == A_CAL_CTRL) begin
        ctrl_reg <= wr_data_reg & CTRL_MASK;
      end
      if (wr_addr_reg == A_COEFF_IDX) begin
        index_reg <= wr_data_reg;
      end
      if (wr_addr_reg == A_CAL_CMD) begin
        cmd_reg <= wr_data_reg & CMD_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      uncal_i_reg <= UNCAL_RST;
      uncal_q_reg <= UNCAL_RST;
    end else if (wr_commit_reg && (wr_addr_reg == A_CAL_CMD) &&
                 (wr_data_reg == REG_RST)) begin
      uncal_i_reg <= 1'b0;
      uncal_q_reg <= 1'b0;
    end
  end

  // start on a zero-to-one write of the start bit
  assign start_pulse = wr_commit_reg && (wr_addr_reg == A_CAL_CMD) &&
    wr_data_reg[B_START] && !cmd_reg[B_START];

  // store only while write bit set
  assign coeff_wr = wr_commit_reg && (wr_addr_reg == A_COEFF_DATA) &&
    cmd_reg[B_WR] && slot_info[SLOT_W];

  // divider length from the select field
  assign div_n = dacsc_div_count(ctrl_reg[B_DIV_MSB:B_DIV_LSB]);

  // divider held in reset while clock disabled
  // the output is high for the first half of each cal cycle
  always_ff @(posedge clk) begin
    if (!reset_n || !ctrl_reg[B_CLK_EN]) begin
      div_cnt_reg <= '0;
      cal_tick_reg <= 1'b0;
      cal_clock_reg <= 1'b0;
    end else if (div_cnt_reg >= div_n - DIV_W'(1)) begin
      div_cnt_reg <= '0;
      cal_tick_reg <= 1'b1;
      cal_clock_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      cal_tick_reg <= 1'b0;
      if (div_cnt_reg == (div_n >> 1) - DIV_W'(1)) begin
        cal_clock_reg <= 1'b0;
      end
    end
  end

  assign cal_clock_out = cal_clock_reg;

  // select bits gate start and writes
  dacsc_cal_engine u_eng_i (
    .clk(clk),
    .reset_n(reset_n),
    .cal_tick(cal_tick_reg),
    .start(start_pulse && ctrl_reg[B_SEL_I]),
    .wr_en(coeff_wr && ctrl_reg[B_SEL_I]),
    .wr_slot(slot_info[SLOT_W-1:0]),
    .wr_data(wr_data_reg[FIELD_W-1:0]),
    .rd_slot(slot_info[SLOT_W-1:0]),
    .rd_data(rd_i),
    .busy(busy_i),
    .done(done_i)
  );

  dacsc_cal_engine u_eng_q (
    .clk(clk),
    .reset_n(reset_n),
    .cal_tick(cal_tick_reg),
    .start(start_pulse && ctrl_reg[B_SEL_Q]),
    .wr_en(coeff_wr && ctrl_reg[B_SEL_Q]),
    .wr_slot(slot_info[SLOT_W-1:0]),
    .wr_data(wr_data_reg[FIELD_W-1:0]),
    .rd_slot(slot_info[SLOT_W-1:0]),
    .rd_data(rd_q),
    .busy(busy_q),
    .done(done_q)
  );

  // progress flags to the pins, one cycle behind the engines
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cal_run_i <= 1'b0;
      cal_run_q <= 1'b0;
    end else begin
      cal_run_i <= busy_i;
      cal_run_q <= busy_q;
    end
  end

  // gap between cal ticks, for checking only
  logic [DIV_W-1:0] gap_cnt;
  logic gap_valid;
  always_ff @(posedge clk) begin
    if (!reset_n || !ctrl_reg[B_CLK_EN]) begin
      gap_cnt <= '0;
      gap_valid <= 1'b0;
    end else if (cal_tick_reg) begin
      gap_cnt <= DIV_W'(1);
      gap_valid <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + DIV_W'(1);
    end
  end

  // a tick may still show in the cycle after the enable drops; judge it
  // by the enable that the divider saw when it made the tick
  a_tick_enable: assert property (@(posedge clk) disable iff (!reset_n)
    cal_tick_reg || cal_clock_reg |-> $past(ctrl_reg[B_CLK_EN]))
    else $error("cal tick while cal clock disabled");

  a_tick_spacing: assert property (@(posedge clk) disable iff (!reset_n)
    cal_tick_reg && gap_valid && $stable(ctrl_reg) |->
      gap_cnt >= DIV_W'(CAL_DIV_MIN) && gap_cnt <= DIV_W'(CAL_DIV_MAX))
    else $error("cal clock period outside 32 to 2048");

  a_sel_routes: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy_q) |-> $past(ctrl_reg[B_SEL_Q]) && $past(start_pulse))
    else $error("q engine started without being selected");

  a_done_status: assert property (@(posedge clk) disable iff (!reset_n)
    done_i && (rd_addr == A_CAL_STAT) |-> rd_mux[B_DONE_I])
    else $error("status does not show i completion");

  a_uncal_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wr_commit_reg && (wr_addr_reg == A_CAL_CMD) && (wr_data_reg == REG_RST)
      |=> !uncal_i_reg && !uncal_q_reg)
    else $error("zero command left uncalibrated set");

  a_read_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_addr == A_COEFF_DATA) && !cmd_reg[B_RD] |-> rd_mux == REG_RST)
    else $error("coefficient data visible without read bit");

  a_trim_write: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(trim_out.coarse_gain_q) |->
      $past(wr_commit_reg) && ($past(wr_addr_reg) == A_Q_COARSE))
    else $error("q coarse gain changed without its write");

  a_index_select: assert property (@(posedge clk) disable iff (!reset_n)
    (index_reg == COEFF_FIRST) |-> slot_info == {1'b1, SLOT_W'(0)})
    else $error("first index does not map to first slot");

endmodule : dacsc_top

// file: bench/dacsc_host.sv
// dacsc_host: host model that drives the serial register port.
// assumes clk is the converter clock; frames are always sent whole
`timescale 1ns/1ps
module dacsc_host
  import dacsc_pkg::*;
(
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdio
);
  localparam int HP = 4; // sclk low clk count, high phase is one more
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdio = 1'b0;
  end
  // one 16-bit frame, msb first; read bits taken just before each rise
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat);
    logic [15:0] f;
    f = {rd, 2'b00, a, wd};
    rdat = '0;
    @(negedge clk) cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk) sclk = 1'b0;
      // a released line toggles so a stale level never passes
      sdio = (rd && i < 8) ? ~sdio : f[i];
      repeat (HP) @(negedge clk);
      if (rd && i < 8) rdat[i] = sdio_oe ? sdio_out : 1'bx;
      sclk = 1'b1;
      repeat (HP) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (HP) @(negedge clk);
    cs_n = 1'b1;
    sdio = ~sdio;
    repeat (HP) @(negedge clk);
  endtask : xfer
endmodule : dacsc_host

// file: bench/testbench.sv
// testbench: register model of the control block compared at every read.
// assumes the host model frames every access; one 100 MHz clock
`timescale 1ns/1ps
module testbench;
  import dacsc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sclk, host_sdio, sdio_in, sdio_out, sdio_oe;
  logic cal_clock_out, cal_run_i, cal_run_q, cc_prev;
  dacsc_trim_t trim_out;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int per = 0;
  int since = 0;
  int mem_m [2][32];
  int trim_a [7] = '{3, 4, 5, 6, 7, 8, 13};
  logic [DATA_W-1:0] reg_m [32] = '{default: 8'h00};
  logic [DATA_W-1:0] stat_m, rv;
  always #5 clk = ~clk;
  // wire level of the shared data pin
  assign sdio_in = sdio_oe ? sdio_out : host_sdio;
  dacsc_top dut (.clk(clk), .reset_n(reset_n), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_sdio_in(sdio_in), .spi_sdio_out(sdio_out),
    .spi_sdio_oe(sdio_oe), .trim_out(trim_out),
    .cal_clock_out(cal_clock_out), .cal_run_i(cal_run_i),
    .cal_run_q(cal_run_q));
  dacsc_host host (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .cs_n(cs_n), .sclk(sclk), .sdio(host_sdio));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [41:0] exp,
      input logic [41:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // cal clock period in clk cycles, and the hang limit
  always @(posedge clk) begin
    cc_prev <= cal_clock_out;
    since <= (cal_clock_out && !cc_prev) ? 1 : since + 1;
    if (cal_clock_out && !cc_prev) per <= since;
    cycles++;
    if (cycles == 100000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [DATA_W-1:0] exp_rd(input int a);
    int k;
    k = reg_m[A_COEFF_IDX];
    if (a == A_CAL_STAT) return stat_m;
    if (a != A_COEFF_DATA) return reg_m[a];
    if (!reg_m[A_CAL_CMD][B_RD] || k < 1 || k > 32) return 8'h00;
    if (reg_m[A_CAL_CTRL][B_SEL_I]) return DATA_W'(mem_m[0][k-1]);
    return DATA_W'(mem_m[1][k-1]);
  endfunction : exp_rd
  // write through the port and update the model
  task automatic wr(input int a, input int d);
    logic [DATA_W-1:0] c;
    int k;
    c = reg_m[A_CAL_CTRL];
    k = reg_m[A_COEFF_IDX];
    host.xfer(1'b0, ADDR_W'(a), DATA_W'(d), rv);
    case (a)
      3, 4, 5, 6, 7, 8, 13, 14: reg_m[a] = DATA_W'(d) & 8'h3F;
      16: reg_m[a] = DATA_W'(d);
      18: begin
        reg_m[a] = DATA_W'(d) & 8'h1C;
        if (d == 0) stat_m[1:0] = 2'b00;
      end
      17: if (reg_m[18][B_WR] && k >= 1 && k <= 32) begin
        if (c[B_SEL_I]) mem_m[0][k-1] = d & 8'h3F;
        if (c[B_SEL_Q]) mem_m[1][k-1] = d & 8'h3F;
      end
      default: ;
    endcase
  endtask : wr
  task automatic rd(input int a, input string what);
    host.xfer(1'b1, ADDR_W'(a), 8'h00, rv);
    check(what, exp_rd(a), rv);
  endtask : rd
  initial begin
    void'($urandom(32'h56f2));
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    stat_m = 8'h03;
    // every address after reset, unmapped ones read zero
    for (int a = 0; a < 32; a++) rd(a, "reset read");
    check("trim reset", 42'h0, trim_out);
    check("cal clock reset", 42'h0, cal_clock_out);
    $display("test reset done");
    // random trim values, upper bits dropped, status and hole ignored
    foreach (trim_a[i]) wr(trim_a[i], $urandom);
    wr(A_CAL_STAT, 8'hFF);
    wr(31, $urandom);
    foreach (trim_a[i]) rd(trim_a[i], "trim reg");
    rd(A_CAL_STAT, "status");
    rd(31, "unmapped");
    check("trim out", {reg_m[13][5:0], reg_m[3][5:0], reg_m[4][5:0],
      reg_m[5][5:0], reg_m[6][5:0], reg_m[7][5:0], reg_m[8][5:0]},
      trim_out);
    wr(A_CAL_CMD, 8'h00);
    rd(A_CAL_STAT, "uncal cleared");
    $display("test trim done");
    // load all coefficients of one channel, then read them back
    for (int ch = 0; ch < 2; ch++) begin
      wr(A_CAL_CTRL, ch ? 8'h20 : 8'h10);
      wr(A_COEFF_IDX, 1);
      wr(A_COEFF_DATA, $urandom);
      wr(A_CAL_CMD, 8'h08);
      for (int k = 1; k <= 32; k++) begin
        wr(A_COEFF_IDX, k);
        wr(A_COEFF_DATA, $urandom);
      end
      wr(A_CAL_CMD, 8'h00);
      // indices 0 and 33 lie outside the store and must read zero
      for (int k = 0; k <= 33; k++) begin
        wr(A_COEFF_IDX, k);
        wr(A_CAL_CMD, 8'h04);
        rd(A_COEFF_DATA, "coefficient");
        wr(A_CAL_CMD, 8'h00);
      end
    end
    // both selected: a write lands in both, a read answers from I
    wr(A_CAL_CTRL, 8'h30);
    wr(A_CAL_CMD, 8'h08);
    wr(A_COEFF_IDX, 32);
    wr(A_COEFF_DATA, $urandom);
    wr(A_CAL_CMD, 8'h04);
    rd(A_COEFF_DATA, "both coefficient i");
    wr(A_CAL_CTRL, 8'h20);
    rd(A_COEFF_DATA, "both coefficient q");
    wr(A_CAL_CMD, 8'h00);
    $display("test coefficients done");
    // I alone at divider select 0, a 3.125 MHz cal clock
    wr(A_CAL_CTRL, 8'h18);
    wr(A_CAL_CMD, 8'h10);
    stat_m = 8'h04;
    repeat (80) @(negedge clk);
    check("cal period", 42'(CAL_DIV_MIN), 42'(per));
    check("q idle", 42'h0, cal_run_q);
    check("i run", 42'h1, cal_run_i);
    repeat (CAL_STEPS * 32 - 800) @(negedge clk);
    rd(A_CAL_STAT, "busy");
    repeat (1200) @(negedge clk);
    stat_m = 8'h40;
    rd(A_CAL_STAT, "done");
    wr(A_CAL_CMD, 8'h00);
    wr(A_CAL_CTRL, 8'h10);
    repeat (40) @(negedge clk);
    check("cal clock off", 42'h0, cal_clock_out);
    rd(A_CAL_STAT, "done held");
    $display("test calibration done");
    // both channels at once; a 128-cycle cal clock is measured first
    wr(A_CAL_CTRL, 8'h3A);
    repeat (400) @(negedge clk);
    check("cal period sel 2", 42'(CAL_DIV_MIN << 2), 42'(per));
    wr(A_CAL_CTRL, 8'h38);
    wr(A_CAL_CMD, 8'h10);
    stat_m = 8'h0C;
    repeat (80) @(negedge clk);
    check("both i run", 42'h1, cal_run_i);
    check("both q run", 42'h1, cal_run_q);
    repeat (CAL_STEPS * CAL_DIV_MIN + 200) @(negedge clk);
    stat_m = 8'hC0;
    rd(A_CAL_STAT, "both done");
    wr(A_CAL_CMD, 8'h00);
    wr(A_CAL_CTRL, 8'h00);
    $display("test dual calibration done");
    // reset after the dual run: trims, flags and status return to reset state
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    reg_m = '{default: 8'h00};
    stat_m = 8'h03;
    check("trim after reset", 42'h0, trim_out);
    rd(A_CAL_STAT, "status after reset");
    $display("test second reset done");
    conclude();
  end
endmodule : testbench
